// >>> sci_card_if.v
/*
 * Subscriber card interface: card clock generator, transmit and receive
 * paths with FIFOs, presence detect and the hardware power-down sequencer.
 * Assumes one 100 MHz clock sys_clk, synchronous active-low rstn, and
 * external pull-ups on the card I/O and presence lines.
 */
//
// Behaviour
// - two card ports, either selectable for the card
// - host control reaches the block as 1-bit plain ports plus an 8-bit divider
// - regulator on only while supply-enable pin and serial enable are high
// - supply removed before card loses contact on removal
// - one clock generator makes internal clocks and card clock
// - clock generator raises no interrupts
// - transmit: state machine, shift register, FIFO feeding the shifter
// - receive: state machine, FIFO and control logic
// - presence input senses insertion and removal, maskable interrupt
// - removal is a high-to-low edge on presence input
// - power-down: reset low, clock low, I/O low, supply off
// - automatic power-down on presence event when enabled
// - forced power-down regardless of enable or presence event
`timescale 1ns/100ps
`default_nettype none
`include "sci_defines.vh"

// ****************************************************************
// simple synchronous fifo
// ****************************************************************
module sci_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // fill side
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    // drain side
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire do_wr;
    wire do_rd;

    // handshakes and flags
    assign in_ready = (count_reg != DEPTH);
    assign out_valid = (count_reg != 0);
    assign out_data = mem[rd_ptr_reg];
    assign do_wr = in_valid & in_ready;
    assign do_rd = out_valid & out_ready;

    // storage
    always @(posedge sys_clk) begin
        if (do_wr) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and fill count
    always @(posedge sys_clk) begin
        if (!rstn) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) wr_ptr_reg <= wr_ptr_reg + 1'b1;
            if (do_rd) rd_ptr_reg <= rd_ptr_reg + 1'b1;
            if (do_wr && !do_rd) count_reg <= count_reg + 1'b1;
            else if (do_rd && !do_wr) count_reg <= count_reg - 1'b1;
        end
    end
endmodule // sci_fifo

// ****************************************************************
// card interface top
// ****************************************************************
module sci_card_if (
    // clock and reset
    input wire sys_clk,
    input wire rstn,
    // host control
    input wire port_select,
    input wire card_power_on,
    input wire card_rst_release,
    input wire card_clk_run,
    input wire [7:0] clk_half_div,
    input wire auto_pd_enable,
    input wire force_pd,
    input wire presence_irq_mask,
    input wire presence_irq_clear,
    // host status
    output reg pd_done,
    output reg presence_flag,
    output reg presence_irq,
    output reg card_present,
    output reg rx_parity_error,
    // transmit data
    input wire [7:0] tx_data,
    input wire tx_valid,
    output wire tx_ready,
    // receive data
    output wire [7:0] rx_data,
    output wire rx_valid,
    input wire rx_ready,
    // regulator
    output reg card_supply_enable_pin,
    // card port 0
    output reg card0_rst,
    output reg card0_clk,
    output reg card0_io_out,
    output reg card0_io_oe_n,
    input wire card0_io_in,
    input wire card0_presence_detect,
    // card port 1
    output reg card1_rst,
    output reg card1_clk,
    output reg card1_io_out,
    output reg card1_io_oe_n,
    input wire card1_io_in,
    input wire card1_presence_detect
);
    reg [1:0] io_sync_reg;
    reg [1:0] pd_sync_reg;
    reg io_prev_reg;
    reg pres_prev_reg;
    reg [7:0] div_cnt_reg;
    reg clk_int_reg;
    reg [2:0] pd_state_reg;
    reg [8:0] pd_wait_reg;
    reg tx_state_reg;
    reg [10:0] tx_shift_reg;
    reg [3:0] tx_bits_reg;
    reg [7:0] tx_etu_reg;
    reg rx_state_reg;
    reg [9:0] rx_shift_reg;
    reg [3:0] rx_bits_reg;
    reg [7:0] rx_etu_reg;
    reg rx_push_reg;
    wire rise_tick;
    wire pres_event;
    wire tx_fifo_valid;
    wire [7:0] tx_fifo_data;
    wire tx_take;
    wire rx_fifo_ready;
    wire pd_active;
    wire pd_step;
    wire [8:0] card_period;

    // even parity over one character
    function parity8;
        input [7:0] d;
        begin
            parity8 = ^d;
        end
    endfunction

    // two-flop synchronisers on the selected port's inputs
    always @(posedge sys_clk) begin
        if (!rstn) begin
            io_sync_reg <= 2'h3;
            pd_sync_reg <= 2'h3;
        end else begin
            io_sync_reg <= {io_sync_reg[0], port_select ? card1_io_in : card0_io_in};
            pd_sync_reg <= {pd_sync_reg[0], port_select ? card1_presence_detect : card0_presence_detect};
        end
    end

    // clock generator, internal tick and card clock; no interrupt source
    assign rise_tick = (div_cnt_reg == clk_half_div) & ~clk_int_reg;
    always @(posedge sys_clk) begin
        if (!rstn) begin
            div_cnt_reg <= 8'h00;
            clk_int_reg <= 1'b0;
        end else if (div_cnt_reg == clk_half_div) begin
            div_cnt_reg <= 8'h00;
            clk_int_reg <= ~clk_int_reg;
        end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
        end
    end

    // presence edges: high-to-low is removal, low-to-high insertion
    assign pres_event = (pres_prev_reg != pd_sync_reg[1]);
    always @(posedge sys_clk) begin
        if (!rstn) begin
            pres_prev_reg <= 1'b1;
            io_prev_reg <= 1'b1;
            presence_flag <= 1'b0;
            presence_irq <= 1'b0;
            card_present <= 1'b0;
        end else begin
            pres_prev_reg <= pd_sync_reg[1];
            io_prev_reg <= io_sync_reg[1];
            card_present <= ~pd_sync_reg[1] ? 1'b0 : 1'b1;
            if (pres_event) presence_flag <= 1'b1; // set wins over clear
            else if (presence_irq_clear) presence_flag <= 1'b0;
            presence_irq <= presence_flag & presence_irq_mask;
        end
    end

    // power-down sequencer, one card clock period plus one cycle per step
    assign card_period = {clk_half_div, 1'b0} + 9'h002;
    assign pd_active = (pd_state_reg != `SCI_PD_IDLE);
    assign pd_step = (pd_wait_reg == card_period);
    always @(posedge sys_clk) begin
        if (!rstn) begin
            pd_state_reg <= `SCI_PD_IDLE;
            pd_wait_reg <= 9'h000;
            pd_done <= 1'b0;
        end else begin
            pd_wait_reg <= (pd_step || pd_state_reg == `SCI_PD_IDLE) ? 9'h000 : pd_wait_reg + 9'h001;
            case (pd_state_reg)
                `SCI_PD_IDLE: begin
                    pd_done <= 1'b0;
                    if (force_pd || (pres_event && auto_pd_enable)) begin
                        pd_state_reg <= `SCI_PD_RST;
                    end
                end
                `SCI_PD_RST: if (pd_step) pd_state_reg <= `SCI_PD_CLK;
                `SCI_PD_CLK: if (pd_step) pd_state_reg <= `SCI_PD_IO;
                `SCI_PD_IO: if (pd_step) pd_state_reg <= `SCI_PD_VCC;
                `SCI_PD_VCC: if (pd_step) begin
                    pd_state_reg <= `SCI_PD_DONE;
                    pd_done <= 1'b1;
                end
                `SCI_PD_DONE: begin
                    if (!card_power_on) pd_state_reg <= `SCI_PD_IDLE; // software restarts power-up
                end
                default: pd_state_reg <= `SCI_PD_IDLE;
            endcase
        end
    end

    // transmit fifo feeding the shifter
    sci_fifo #(
        .WIDTH(`SCI_FIFO_WIDTH),
        .DEPTH(`SCI_FIFO_DEPTH),
        .AW(`SCI_FIFO_AW)
    ) u_tx_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_data(tx_data),
        .in_valid(tx_valid),
        .in_ready(tx_ready),
        .out_data(tx_fifo_data),
        .out_valid(tx_fifo_valid),
        .out_ready(tx_take)
    );

    // transmit state machine: start, 8 data lsb first, even parity, stop
    assign tx_take = (tx_state_reg == `SCI_TX_IDLE) && tx_fifo_valid && !pd_active
                     && card_power_on && (rx_state_reg == `SCI_RX_IDLE);
    always @(posedge sys_clk) begin
        if (!rstn) begin
            tx_state_reg <= `SCI_TX_IDLE;
            tx_shift_reg <= 11'h7FF;
            tx_bits_reg <= 4'h0;
            tx_etu_reg <= 8'h00;
        end else begin
            case (tx_state_reg)
                `SCI_TX_IDLE: begin
                    if (tx_take) begin
                        tx_shift_reg <= {1'b1, parity8(tx_fifo_data), tx_fifo_data, 1'b0};
                        tx_bits_reg <= 4'h0;
                        tx_etu_reg <= 8'h00;
                        tx_state_reg <= `SCI_TX_SHIFT;
                    end
                end
                `SCI_TX_SHIFT: begin
                    if (pd_active) begin
                        tx_state_reg <= `SCI_TX_IDLE;
                        tx_shift_reg <= 11'h7FF;
                    end else if (rise_tick) begin
                        if (tx_etu_reg == `SCI_ETU_CLKS - 8'h01) begin
                            tx_etu_reg <= 8'h00;
                            tx_shift_reg <= {1'b1, tx_shift_reg[10:1]};
                            tx_bits_reg <= tx_bits_reg + 4'h1;
                            if (tx_bits_reg == `SCI_TX_BITS - 4'h1) tx_state_reg <= `SCI_TX_IDLE;
                        end else begin
                            tx_etu_reg <= tx_etu_reg + 8'h01;
                        end
                    end
                end
                default: tx_state_reg <= `SCI_TX_IDLE;
            endcase
        end
    end

    // receive state machine: sample mid-bit, check start and parity
    always @(posedge sys_clk) begin
        if (!rstn) begin
            rx_state_reg <= `SCI_RX_IDLE;
            rx_shift_reg <= 10'h000;
            rx_bits_reg <= 4'h0;
            rx_etu_reg <= 8'h00;
            rx_push_reg <= 1'b0;
            rx_parity_error <= 1'b0;
        end else begin
            rx_push_reg <= 1'b0;
            rx_parity_error <= 1'b0;
            case (rx_state_reg)
                `SCI_RX_IDLE: begin
                    if (io_prev_reg && !io_sync_reg[1] && tx_state_reg == `SCI_TX_IDLE
                        && card_power_on && !pd_active) begin
                        rx_etu_reg <= `SCI_ETU_CLKS - `SCI_ETU_HALF;
                        rx_bits_reg <= 4'h0;
                        rx_state_reg <= `SCI_RX_DATA;
                    end
                end
                `SCI_RX_DATA: begin
                    if (pd_active) begin
                        rx_state_reg <= `SCI_RX_IDLE;
                    end else if (rise_tick) begin
                        if (rx_etu_reg == `SCI_ETU_CLKS - 8'h01) begin
                            rx_etu_reg <= 8'h00;
                            rx_shift_reg <= {io_sync_reg[1], rx_shift_reg[9:1]};
                            rx_bits_reg <= rx_bits_reg + 4'h1;
                            if (rx_bits_reg == `SCI_RX_BITS - 4'h1) begin
                                rx_state_reg <= `SCI_RX_IDLE;
                                if ((parity8(rx_shift_reg[9:2]) != io_sync_reg[1]) || rx_shift_reg[1])
                                    rx_parity_error <= 1'b1;
                                else
                                    rx_push_reg <= 1'b1; // good character into fifo
                            end
                        end else begin
                            rx_etu_reg <= rx_etu_reg + 8'h01;
                        end
                    end
                end
                default: rx_state_reg <= `SCI_RX_IDLE;
            endcase
        end
    end

    // receive fifo; a full fifo drops the character
    sci_fifo #(
        .WIDTH(`SCI_FIFO_WIDTH),
        .DEPTH(`SCI_FIFO_DEPTH),
        .AW(`SCI_FIFO_AW)
    ) u_rx_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_data(rx_shift_reg[8:1]),
        .in_valid(rx_push_reg),
        .in_ready(rx_fifo_ready),
        .out_data(rx_data),
        .out_valid(rx_valid),
        .out_ready(rx_ready)
    );

    // card pins, supply pin and port routing
    always @(posedge sys_clk) begin
        if (!rstn) begin
            card_supply_enable_pin <= 1'b0;
            card0_rst <= 1'b0;
            card0_clk <= 1'b0;
            card0_io_out <= 1'b0;
            card0_io_oe_n <= 1'b1;
            card1_rst <= 1'b0;
            card1_clk <= 1'b0;
            card1_io_out <= 1'b0;
            card1_io_oe_n <= 1'b1;
        end else begin
            card_supply_enable_pin <= card_power_on && (pd_state_reg < `SCI_PD_VCC);
            card0_rst <= !port_select && card_rst_release && !pd_active;
            card1_rst <= port_select && card_rst_release && !pd_active;
            card0_clk <= !port_select && card_clk_run && clk_int_reg
                         && (pd_state_reg < `SCI_PD_CLK); // clock stops low
            card1_clk <= port_select && card_clk_run && clk_int_reg && (pd_state_reg < `SCI_PD_CLK);
            card0_io_out <= 1'b0;
            card1_io_out <= 1'b0;
            // drive low for a zero bit or once the I/O step is reached
            card0_io_oe_n <= port_select || !((pd_state_reg >= `SCI_PD_IO) ||
                             (tx_state_reg == `SCI_TX_SHIFT && !tx_shift_reg[0]));
            card1_io_oe_n <= !port_select || !((pd_state_reg >= `SCI_PD_IO) ||
                             (tx_state_reg == `SCI_TX_SHIFT && !tx_shift_reg[0]));
        end
    end
endmodule // sci_card_if
`default_nettype wire

// >>> sci_defines.vh
/*
 * Constants of the subscriber card interface: character framing,
 * transmit and receive states, power-down sequencer and FIFO.
 * Assumes inclusion by the card interface design file only.
 */
`ifndef SCI_DEFINES_VH
`define SCI_DEFINES_VH

// ****************************************************************
// character framing
// ****************************************************************
`define SCI_ETU_CLKS 8'h10
`define SCI_ETU_HALF 8'h08
`define SCI_TX_BITS 4'hB
`define SCI_RX_BITS 4'hA

// ****************************************************************
// fifo geometry
// ****************************************************************
`define SCI_FIFO_WIDTH 8
`define SCI_FIFO_DEPTH 8
`define SCI_FIFO_AW 3

// ****************************************************************
// power-down sequencer states
// ****************************************************************
`define SCI_PD_IDLE 3'h0
`define SCI_PD_RST 3'h1
`define SCI_PD_CLK 3'h2
`define SCI_PD_IO 3'h3
`define SCI_PD_VCC 3'h4
`define SCI_PD_DONE 3'h5

// ****************************************************************
// transmit and receive states
// ****************************************************************
`define SCI_TX_IDLE 1'h0
`define SCI_TX_SHIFT 1'h1
`define SCI_RX_IDLE 1'h0
`define SCI_RX_DATA 1'h1

`endif

// >>> sci_card_if_properties.sv
/*
 * Port-level properties of the card interface: presence flag, interrupt,
 * power-down order and spacing, idle state of the unselected port.
 * Assumes clk_half_div is 3, so one card clock period is 8 cycles.
 */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// checker
// ****************************************************************
module sci_card_if_properties (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // host control
    input wire logic port_select,
    input wire logic card_power_on,
    input wire logic auto_pd_enable,
    input wire logic force_pd,
    input wire logic presence_irq_mask,
    input wire logic presence_irq_clear,
    // host status
    input wire logic pd_done,
    input wire logic presence_flag,
    input wire logic presence_irq,
    input wire logic card_present,
    input wire logic card_supply_enable_pin,
    // card pins
    input wire logic card0_rst,
    input wire logic card0_clk,
    input wire logic card0_io_oe_n,
    input wire logic card1_rst,
    input wire logic card1_clk,
    input wire logic card1_io_oe_n
);
    // pins of the selected and of the idle port
    wire sel_rst = port_select ? card1_rst : card0_rst;
    wire sel_clk = port_select ? card1_clk : card0_clk;
    wire sel_oe_n = port_select ? card1_io_oe_n : card0_io_oe_n;
    wire un_busy = port_select ? (card0_rst | card0_clk | !card0_io_oe_n) : (card1_rst | card1_clk | !card1_io_oe_n);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    AST_IRQ_GATED: assert property (presence_irq == ($past(presence_flag) & $past(presence_irq_mask)))
        else $error("presence_irq differs from flag and mask");
    AST_FLAG_STICKY: assert property (presence_flag && !presence_irq_clear |=> presence_flag)
        else $error("presence_flag dropped without clear");
    AST_REMOVAL_FLAG: assert property ($fell(card_present) |-> ##[0:3] presence_flag)
        else $error("removal edge did not set presence_flag");
    AST_PD_STATE: assert property (pd_done && card_power_on |-> !card_supply_enable_pin && !sel_rst && !sel_clk && !sel_oe_n)
        else $error("pd_done with a card pin still active");
    AST_STEP_SPACING: assert property ($fell(card_supply_enable_pin) && card_power_on |-> !$past(sel_oe_n, 8) && !$past(sel_rst, 16))
        else $error("supply dropped too soon after io or reset step");
    AST_FORCE_DONE: assert property (force_pd && card_power_on && !pd_done |-> ##[1:64] pd_done)
        else $error("forced power-down did not complete");
    AST_AUTO_DONE: assert property ($rose(presence_flag) && auto_pd_enable && card_power_on |-> ##[1:64] pd_done)
        else $error("automatic power-down did not complete");
    AST_IDLE_PORT: assert property (port_select == $past(port_select) && port_select == $past(port_select, 2) |-> !un_busy)
        else $error("unselected port not idle");
endmodule // sci_card_if_properties

bind sci_card_if sci_card_if_properties u_props (.sys_clk(sys_clk), .rstn(rstn), .port_select(port_select),
    .card_power_on(card_power_on), .auto_pd_enable(auto_pd_enable), .force_pd(force_pd),
    .presence_irq_mask(presence_irq_mask), .presence_irq_clear(presence_irq_clear), .pd_done(pd_done),
    .presence_flag(presence_flag), .presence_irq(presence_irq), .card_present(card_present),
    .card_supply_enable_pin(card_supply_enable_pin), .card0_rst(card0_rst), .card0_clk(card0_clk),
    .card0_io_oe_n(card0_io_oe_n), .card1_rst(card1_rst), .card1_clk(card1_clk), .card1_io_oe_n(card1_io_oe_n));
`default_nettype wire

// >>> sci_card_model.sv
/*
 * Behavioural card with its supply regulator: decodes characters from the
 * open-drain I/O line and sends characters back, with good or bad parity.
 * Assumes external pull-up on the line and a card clock from the block.
 */
`timescale 1ns/100ps
`default_nettype none

// ****************************************************************
// card model
// ****************************************************************
module sci_card_model (
    // card pins
    input wire logic card_clk,
    input wire logic card_rst,
    input wire logic io_oe_n,
    input wire logic card_supply_enable_pin,
    // resolved line level
    output wire logic io_line
);
    logic drive = 1'b1;
    logic busy = 1'b0;
    logic card_regulator_serial_enable = 1'b1;
    logic card_voltage_select = 1'b0; // lower supply level chosen
    logic [10:0] sh;
    integer cnt = 0;
    logic [7:0] got[$];
    logic ok[$];
    // regulator on only with pin and serial enable both high
    wire powered = card_supply_enable_pin & card_regulator_serial_enable;
    // open drain with pull-up: low when either end pulls low
    assign io_line = io_oe_n & (drive | !powered);

    // character receiver, samples mid-bit every 16 card clocks
    always @(posedge card_clk) begin
        if (!drive || !card_rst || !powered) begin
            busy = 1'b0;
        end else if (!busy) begin
            busy = !io_line;
            cnt = 0;
        end else begin
            cnt = cnt + 1;
            if (cnt % 16 == 8) begin
                sh = {io_line, sh[10:1]};
                if (cnt == 168) begin
                    busy = 1'b0;
                    got.push_back(sh[8:1]);
                    ok.push_back(!sh[0] && sh[10] && !(^sh[9:1]));
                end
            end
        end
    end

    // send one character, start low, lsb first, even parity, stop high
    task send(input logic [7:0] b, input logic bad);
        logic [10:0] f;
        begin
            f = {1'b1, (^b) ^ bad, b, 1'b0};
            for (int i = 0; i < 11; i++) begin
                drive = f[i];
                repeat (16) @(posedge card_clk);
            end
            drive = 1'b1;
        end
    endtask
endmodule // sci_card_model
`default_nettype wire

// >>> sci_card_if_tb.sv
/*
 * Self-checking bench of the card interface: FIFO fill, transmit, receive,
 * presence events, automatic and forced power-down, port selection.
 * Assumes sci_card_model on port 0 and a pulled-up idle port 1.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("Error %s expected %0h seen %0h", nm, e, a); end end

// ****************************************************************
// testbench top
// ****************************************************************
module sci_card_if_tb;
    logic sys_clk = 1'b0, rstn = 1'b0, port_select = 1'b0, card_power_on = 1'b0, card_rst_release = 1'b0;
    logic card_clk_run = 1'b0, auto_pd_enable = 1'b0, force_pd = 1'b0, presence_irq_mask = 1'b0;
    logic presence_irq_clear = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0, pres0 = 1'b1, pres1 = 1'b1;
    logic [7:0] clk_half_div = 8'h03, tx_data = 8'h00, d;
    logic [7:0] rxv[4] = '{8'h3C, 8'hC3, 8'h55, 8'h81};
    wire pd_done, presence_flag, presence_irq, card_present, rx_parity_error, tx_ready, rx_valid;
    wire card_supply_enable_pin, card0_rst, card0_clk, card0_io_oe_n, io0, card1_rst, card1_clk, card1_io_oe_n;
    wire [7:0] rx_data;
    integer fail_count = 0, total_checks = 0, perr = 0, n;

    sci_card_if u_dut (.sys_clk(sys_clk), .rstn(rstn), .port_select(port_select), .card_power_on(card_power_on),
        .card_rst_release(card_rst_release), .card_clk_run(card_clk_run), .clk_half_div(clk_half_div),
        .auto_pd_enable(auto_pd_enable), .force_pd(force_pd), .presence_irq_mask(presence_irq_mask),
        .presence_irq_clear(presence_irq_clear), .pd_done(pd_done), .presence_flag(presence_flag),
        .presence_irq(presence_irq), .card_present(card_present), .rx_parity_error(rx_parity_error),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .card_supply_enable_pin(card_supply_enable_pin), .card0_rst(card0_rst),
        .card0_clk(card0_clk), .card0_io_out(), .card0_io_oe_n(card0_io_oe_n), .card0_io_in(io0),
        .card0_presence_detect(pres0), .card1_rst(card1_rst), .card1_clk(card1_clk), .card1_io_out(),
        .card1_io_oe_n(card1_io_oe_n), .card1_io_in(1'b1), .card1_presence_detect(pres1));
    sci_card_model u_card (.card_clk(card0_clk), .card_rst(card0_rst), .io_oe_n(card0_io_oe_n),
        .card_supply_enable_pin(card_supply_enable_pin), .io_line(io0));

    // clock and parity error counter
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (rx_parity_error === 1'b1) perr <= perr + 1;

    task tick(input integer c);
        repeat (c) @(posedge sys_clk);
    endtask

    task end_test(input string s);
        $display("test %s done, checks %0d", s, total_checks);
    endtask

    // offer one byte, hold until taken
    task push(input logic [7:0] b);
        begin
            @(posedge sys_clk);
            tx_data <= b;
            tx_valid <= 1'b1;
            n = 0;
            do begin @(posedge sys_clk); n++; end while (tx_ready !== 1'b1 && n < 3000);
            tx_valid <= 1'b0;
        end
    endtask

    // wait for a byte, then pop it
    task pop(output logic [7:0] b);
        begin
            n = 0;
            do begin @(posedge sys_clk); n++; end while (rx_valid !== 1'b1 && n < 3000);
            rx_ready <= 1'b1;
            @(posedge sys_clk);
            b = rx_data;
            rx_ready <= 1'b0;
        end
    endtask

    // follow a power-down, note when the reset, I/O and supply steps land
    task pd_check;
        integer tr, to, tv;
        begin
            tr = -1;
            to = -1;
            tv = -1;
            for (n = 0; n < 200 && pd_done !== 1'b1; n++) begin
                @(posedge sys_clk);
                if (card0_rst === 1'b0 && tr < 0) tr = n;
                if (card0_io_oe_n === 1'b0 && to < 0) to = n;
                if (card_supply_enable_pin === 1'b0 && tv < 0) tv = n;
            end
            `CHK("pd_done", 1'b1, pd_done)
            `CHK("rst_then_io", 1'b1, tr >= 0 && to - tr >= 8)
            `CHK("io_then_supply", 1'b1, tv - to >= 8)
            `CHK("clk_low", 1'b0, card0_clk)
        end
    endtask

    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", total_checks, fail_count);
            if (fail_count == 0 && total_checks > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask

    // watchdog, well beyond the expected 17500 cycles
    initial begin
        tick(80000);
        fail_count++;
        $display("Error watchdog expected 0 seen 1");
        report_and_stop;
    end

    // main sequence
    initial begin
        tick(20);
        rstn <= 1'b1;
        tick(2);
        `CHK("rst_oe_n", 1'b1, card0_io_oe_n)
        `CHK("rst_supply", 1'b0, card_supply_enable_pin)
        for (int i = 0; i < 8; i++) push(8'h05 + 8'(i * 37));
        tick(2);
        `CHK("tx_full", 1'b0, tx_ready)
        end_test("fill");
        card_power_on <= 1'b1;
        tick(10);
        card_clk_run <= 1'b1;
        tick(10);
        card_rst_release <= 1'b1;
        for (n = 0; n < 16000 && u_card.got.size() < 8; n++) tick(1);
        `CHK("supply_on", 1'b1, card_supply_enable_pin)
        `CHK("tx_count", 8, u_card.got.size())
        for (int i = 0; i < 8 && i < u_card.got.size(); i++) begin
            `CHK("tx_byte", 8'h05 + 8'(i * 37), u_card.got[i])
            `CHK("tx_frame", 1'b1, u_card.ok[i])
        end
        end_test("transmit");
        tick(300);
        for (int i = 0; i < 4; i++) u_card.send(rxv[i], i == 2);
        for (int i = 0; i < 4; i++) begin
            if (i != 2) begin
                pop(d);
                `CHK("rx_byte", rxv[i], d)
            end
        end
        `CHK("rx_parity", 1, perr)
        end_test("receive");
        pres0 <= 1'b0;
        tick(10);
        `CHK("removed", 1'b0, card_present)
        `CHK("flag", 1'b1, presence_flag)
        `CHK("irq_masked", 1'b0, presence_irq)
        `CHK("no_auto", 1'b0, pd_done)
        presence_irq_mask <= 1'b1;
        tick(3);
        `CHK("irq", 1'b1, presence_irq)
        presence_irq_clear <= 1'b1;
        tick(1);
        presence_irq_clear <= 1'b0;
        tick(3);
        `CHK("cleared", 1'b0, presence_flag | presence_irq)
        end_test("presence");
        auto_pd_enable <= 1'b1;
        pres0 <= 1'b1;
        pd_check;
        `CHK("insert_flag", 1'b1, presence_flag)
        end_test("auto power-down");
        card_power_on <= 1'b0;
        auto_pd_enable <= 1'b0;
        tick(5);
        `CHK("pd_done_clear", 1'b0, pd_done)
        card_power_on <= 1'b1;
        tick(50);
        force_pd <= 1'b1;
        tick(1);
        force_pd <= 1'b0;
        pd_check;
        end_test("forced power-down");
        card_power_on <= 1'b0;
        port_select <= 1'b1;
        tick(5);
        card_power_on <= 1'b1;
        tick(50);
        `CHK("port1_rst", 1'b1, card1_rst)
        `CHK("port0_idle", 1'b1, !card0_rst && !card0_clk && card0_io_oe_n)
        `CHK("port1_silent", 1'b0, rx_valid)
        end_test("port select");
        report_and_stop;
    end
endmodule // sci_card_if_tb
`default_nettype wire
